//--- design/hpadr_top.sv
/*
 * Host port address/data registers: halfword ordering, host-to-cpu irq flag,
 * write/read address registers (single or dual mode), data port in front of
 * read and write FIFOs served by internal DMA.
 * Assumes host pins arrive asynchronously; host strobe hst_stb_i toggles-free
 * level, high for one transfer; DMA and CPU ports are on clk_i.
 */
//
// Functional notes
// RQ1 - writing zero to the host-to-cpu irq flag changes nothing
// RQ2 - host writing one sets the flag and interrupts cpu until cleared
// RQ3 - cpu writing one clears the host-to-cpu irq flag
// RQ4 - host sets halfword order first; it matters only in 16-bit mode
// RQ5 - halfword order is mirrored read-only at control bit eight
// RQ6 - order zero write: first halfword high, second halfword low
// RQ7 - order one write: first halfword low, second halfword high
// RQ8 - order zero read: upper half driven first, lower half second
// RQ9 - order one read: lower half driven first, upper half second
// RQ10 - separate 32-bit write and read address registers
// RQ11 - address registers appear combined or independent to host
// RQ12 - mode zero: write loads both, increment both, read returns read address
// RQ13 - mode one: host accesses read and write address independently
// RQ14 - host reads and writes address registers; cpu reads only
// RQ15 - host loads word addresses, not byte addresses
// RQ16 - full written 32-bit data word goes to memory via DMA
// RQ17 - DMA fills data port from memory before host read returns it
// RQ18 - host cycle is one 32-bit or two 16-bit transfers
// RQ19 - data port is host-only; cpu has no path to it
// RQ20 - data reads come from read FIFO, writes enter write FIFO
// RQ21 - 16-bit register write commits after the second halfword
`timescale 1ns/1ns
`include "hpadr_defines.svh"
module hpadr_top #(
	parameter int FIFO_DEPTH = `HPADR_FIFO_DEPTH
)(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// host pins
	input  wire logic                   hst_stb_i,
	input  wire logic                   hst_rnw_i,
	input  wire hpadr_pkg::hpadr_sel_t  hst_sel_i,
	input  wire logic                   hst_mode16_i,
	input  wire logic [31:0]            hst_data_i,
	output logic      [31:0]            hst_data_o,
	output logic                        hst_data_oe_o,
	output logic                        hst_ready_o,
	// on-chip cpu register port
	input  wire logic                   cpu_wr_i,
	input  wire logic                   cpu_rd_i,
	input  wire logic [1:0]             cpu_addr_i,
	input  wire logic [31:0]            cpu_wdata_i,
	output logic      [31:0]            cpu_rdata_o,
	output logic                        host_to_cpu_irq_o,
	// DMA side
	output logic      [31:0]            dma_wr_addr_o,
	output logic      [31:0]            dma_wr_data_o,
	output logic                        dma_wr_valid_o,
	input  wire logic                   dma_wr_ready_i,
	output logic      [31:0]            dma_rd_addr_o,
	output logic                        dma_rd_req_o,
	input  wire logic                   dma_rd_ack_i,
	input  wire logic [31:0]            dma_rd_data_i
);
	import hpadr_pkg::*;

	initial
	begin
		if (FIFO_DEPTH < 2)
			$error("hpadr_top: fifo depth must be at least 2");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int PW = 1 + 1 + 2 + 1 + 32;
	logic [PW-1:0] pins_s;
	logic          stb_s;
	logic          rnw_s;
	hpadr_sel_t    sel_s;
	logic          m16_s;
	logic [31:0]   din_s;
	logic          stb_d;
	logic          stb_rise;

	hpadr_sync #(.WIDTH(PW)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({hst_stb_i, hst_rnw_i, hst_sel_i, hst_mode16_i, hst_data_i}),
		.sync_o  (pins_s)
	);
	assign {stb_s, rnw_s, sel_s, m16_s, din_s} = pins_s;
	assign stb_rise = stb_s && !stb_d;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			stb_d <= 1'b0;
		else
			stb_d <= stb_s;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic         hword_sel;
	logic         addr_mode;
	logic [31:0]  write_address; // see RQ10
	logic [31:0]  read_address; // see RQ10
	logic         irq_flag;
	logic [15:0]  first_half;
	hpadr_state_t state;
	logic         commit;
	logic [31:0]  cword;
	logic         order1;
	logic         wf_in_ready;
	logic [31:0]  wf_data;
	logic         wf_valid;
	logic         wf_ready;
	logic [31:0]  rf_data;
	logic         rf_valid;
	logic         rf_pop;
	logic [31:0]  ctl_word;
	logic [31:0]  rd_word;
	logic         rd_pending;
	logic         wr_push;
	logic         cpu_irq_clr;

	// order applies only in 16-bit mode (see RQ4)
	assign order1 = m16_s && hword_sel;

	// 16-bit: pair halves per order; 32-bit: single transfer (see RQ18)
	always_comb
	begin
		if (!m16_s)
			cword = din_s;
		else if (order1)
			cword = {din_s[15:0], first_half}; // see RQ7
		else
			cword = {first_half, din_s[15:0]}; // see RQ6
	end

	assign ctl_word = {22'h0, addr_mode, hword_sel, 6'h0, irq_flag, hword_sel}; // see RQ5

	always_comb
	begin
		case (sel_s)
			`HPADR_SEL_CTL:   rd_word = ctl_word;
			`HPADR_SEL_WADDR: rd_word = addr_mode ? write_address : read_address; // see RQ12
			`HPADR_SEL_RADDR: rd_word = read_address; // see RQ13
			default:          rd_word = (state == HPADR_HALF2) ? rd_hold : rf_data; // see RQ20
		endcase
	end

	// ----------------------------------------------------------------
	// host cycle sequencing
	// ----------------------------------------------------------------
	assign wr_push = commit && (sel_s == `HPADR_SEL_DATA);
	assign rf_pop  = stb_rise && rnw_s && (sel_s == `HPADR_SEL_DATA) && rf_valid
		&& (state == HPADR_IDLE);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state         <= HPADR_IDLE;
			first_half    <= 16'h0000;
			commit        <= 1'b0;
			hst_data_o    <= `HPADR_RST_WORD;
			hst_data_oe_o <= 1'b0;
		end
		else
		begin
			commit <= 1'b0;
			if (!stb_s)
				hst_data_oe_o <= 1'b0;
			case (state)
				HPADR_IDLE:
				begin
					if (stb_rise && rnw_s)
					begin
						if (sel_s == `HPADR_SEL_DATA && !rf_valid)
							state <= HPADR_RDWT; // see RQ17
						else
						begin
							hst_data_oe_o <= 1'b1;
							if (!m16_s)
								hst_data_o <= rd_word;
							else if (order1)
								hst_data_o <= {16'h0000, rd_word[15:0]}; // see RQ9
							else
								hst_data_o <= {16'h0000, rd_word[31:16]}; // see RQ8
							if (m16_s)
								state <= HPADR_HALF2;
						end
					end
					else if (stb_rise)
					begin
						first_half <= din_s[15:0];
						if (m16_s)
							state <= HPADR_HALF2;
						else
							commit <= 1'b1;
					end
				end
				HPADR_HALF2:
				begin
					if (stb_rise && rnw_s)
					begin
						hst_data_oe_o <= 1'b1;
						hst_data_o    <= {16'h0000, order1 ? rd_word[31:16] : rd_word[15:0]}; // see RQ8
						state         <= HPADR_IDLE;
					end
					else if (stb_rise)
					begin
						commit <= 1'b1; // see RQ21
						state  <= HPADR_IDLE;
					end
				end
				HPADR_RDWT:
				begin
					// cycle retried by host once ready rises
					if (rf_valid || !stb_s)
						state <= HPADR_IDLE;
				end
				default:
					state <= HPADR_IDLE;
			endcase
		end
	end

	// 16-bit data-read second half must see same word; pop on the first half and keep a copy in rd_hold
	logic [31:0] rd_hold;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_hold <= `HPADR_RST_WORD;
		else if (rf_pop)
			rd_hold <= rf_data;
	end

	// ----------------------------------------------------------------
	// control and address registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hword_sel <= 1'b0;
			addr_mode <= 1'b0;
		end
		else if (stb_rise && !rnw_s && !m16_s && sel_s == `HPADR_SEL_CTL)
		begin
			// 32-bit mode ignores order, yet the bit still stores
			hword_sel <= din_s[`HPADR_CTL_HWORD_BIT];
			addr_mode <= din_s[`HPADR_CTL_AMODE_BIT];
		end
		else if (commit && sel_s == `HPADR_SEL_CTL)
		begin
			hword_sel <= cword[`HPADR_CTL_HWORD_BIT];
			addr_mode <= cword[`HPADR_CTL_AMODE_BIT];
		end
	end

	// cpu writes never reach the address registers (see RQ14)
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			write_address <= `HPADR_RST_WORD;
			read_address  <= `HPADR_RST_WORD;
		end
		else
		begin
			if (commit && sel_s == `HPADR_SEL_WADDR)
			begin
				write_address <= cword; // see RQ11
				if (!addr_mode)
					read_address <= cword; // see RQ12
			end
			else if (commit && sel_s == `HPADR_SEL_RADDR && addr_mode)
				read_address <= cword; // see RQ13
			else
			begin
				// autoincrement after each data word moves
				if (wr_push && wf_in_ready)
				begin
					write_address <= write_address + `HPADR_ADDR_STEP;
					if (!addr_mode)
						read_address <= read_address + `HPADR_ADDR_STEP; // see RQ12
				end
				if (dma_rd_req_o && dma_rd_ack_i)
				begin
					read_address <= read_address + `HPADR_ADDR_STEP;
					if (!addr_mode)
						write_address <= write_address + `HPADR_ADDR_STEP;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// host-to-cpu irq flag
	// ----------------------------------------------------------------
	assign cpu_irq_clr = cpu_wr_i && cpu_addr_i == `HPADR_CPU_CTL && cpu_wdata_i[`HPADR_CTL_IRQ_BIT];

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_flag <= 1'b0;
		else if (commit && sel_s == `HPADR_SEL_CTL && cword[`HPADR_CTL_IRQ_BIT])
			irq_flag <= 1'b1; // see RQ2
		else if (stb_rise && !rnw_s && !m16_s && sel_s == `HPADR_SEL_CTL && din_s[`HPADR_CTL_IRQ_BIT])
			irq_flag <= 1'b1; // see RQ2
		else if (cpu_irq_clr)
			irq_flag <= 1'b0; // see RQ3
		// zero writes fall through unchanged (see RQ1)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			host_to_cpu_irq_o <= 1'b0;
			cpu_rdata_o       <= `HPADR_RST_WORD;
		end
		else
		begin
			host_to_cpu_irq_o <= irq_flag;
			// no cpu path to the data port (see RQ19)
			if (cpu_rd_i)
			begin
				case (cpu_addr_i)
					`HPADR_CPU_CTL:   cpu_rdata_o <= ctl_word;
					`HPADR_CPU_WADDR: cpu_rdata_o <= write_address; // see RQ14
					`HPADR_CPU_RADDR: cpu_rdata_o <= read_address;
					default:          cpu_rdata_o <= `HPADR_RST_WORD;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// data FIFOs and DMA
	// ----------------------------------------------------------------
	hpadr_fifo #(.WIDTH(`HPADR_WORD_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (1'b0),
		.in_data_i   (cword),
		.in_valid_i  (wr_push), // see RQ20
		.in_ready_o  (wf_in_ready),
		.out_data_o  (wf_data),
		.out_valid_o (wf_valid),
		.out_ready_i (wf_ready)
	);

	hpadr_fifo #(.WIDTH(`HPADR_WORD_W), .DEPTH(FIFO_DEPTH)) u_rfifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (1'b0),
		.in_data_i   (dma_rd_data_i),
		.in_valid_i  (dma_rd_req_o && dma_rd_ack_i), // see RQ17
		.in_ready_o  (),
		.out_data_o  (rf_data),
		.out_valid_o (rf_valid),
		.out_ready_i (rf_pop)
	);

	// write drain: one word in flight to DMA (see RQ16)
	assign wf_ready = wf_valid && (!dma_wr_valid_o || dma_wr_ready_i);
	logic [31:0] wr_addr_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dma_wr_valid_o <= 1'b0;
			dma_wr_data_o  <= `HPADR_RST_WORD;
			dma_wr_addr_o  <= `HPADR_RST_WORD;
			wr_addr_q      <= `HPADR_RST_WORD;
		end
		else
		begin
			if (commit && sel_s == `HPADR_SEL_WADDR)
				wr_addr_q <= cword;
			if (wf_ready)
			begin
				dma_wr_valid_o <= 1'b1;
				dma_wr_data_o  <= wf_data;
				dma_wr_addr_o  <= wr_addr_q;
				wr_addr_q      <= wr_addr_q + `HPADR_ADDR_STEP;
			end
			else if (dma_wr_ready_i)
				dma_wr_valid_o <= 1'b0;
		end
	end

	// fetch one word when the read FIFO is empty and host waits
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dma_rd_req_o  <= 1'b0;
			dma_rd_addr_o <= `HPADR_RST_WORD;
			rd_pending    <= 1'b0;
		end
		else
		begin
			rd_pending <= (state == HPADR_RDWT);
			if (dma_rd_req_o && dma_rd_ack_i)
				dma_rd_req_o <= 1'b0;
			else if (rd_pending && !rf_valid && !dma_rd_req_o)
			begin
				dma_rd_req_o  <= 1'b1;
				dma_rd_addr_o <= read_address;
			end
		end
	end

	// ready low while write FIFO full or a read waits on DMA
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			hst_ready_o <= 1'b0;
		else
			hst_ready_o <= wf_in_ready && (state != HPADR_RDWT);
	end
endmodule

//--- design/hpadr_defines.svh
/*
 * Constants of the host port address/data register block: field positions,
 * cycle-type codes, reset values.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef HPADR_DEFINES_SVH
`define HPADR_DEFINES_SVH

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define HPADR_CTL_HWORD_BIT   0
`define HPADR_CTL_IRQ_BIT     1
`define HPADR_CTL_AMODE_BIT   9
`define HPADR_CTL_MIRROR_BIT  8

// ----------------------------------------------------------------
// host cycle target codes
// ----------------------------------------------------------------
`define HPADR_SEL_CTL         2'h0
`define HPADR_SEL_WADDR       2'h1
`define HPADR_SEL_RADDR       2'h2
`define HPADR_SEL_DATA        2'h3

// ----------------------------------------------------------------
// cpu-side register offsets (word index)
// ----------------------------------------------------------------
`define HPADR_CPU_CTL         2'h0
`define HPADR_CPU_WADDR       2'h1
`define HPADR_CPU_RADDR       2'h2

`define HPADR_RST_WORD        32'h0000_0000
`define HPADR_ADDR_STEP       32'h0000_0001
`define HPADR_FIFO_DEPTH      32
`define HPADR_WORD_W          32

`endif

//--- design/hpadr_pkg.sv
/*
 * Types shared by the host port address/data register block.
 * Assumes hpadr_defines.svh is compiled alongside.
 */
package hpadr_pkg;
	typedef enum logic [1:0]
	{
		HPADR_IDLE  = 2'b00,
		HPADR_HALF2 = 2'b01,
		HPADR_RDWT  = 2'b10
	} hpadr_state_t;
	typedef logic [1:0] hpadr_sel_t;
endpackage

//--- design/hpadr_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and an active-high asynchronous reset.
 */
`timescale 1ns/1ns
`include "hpadr_defines.svh"
module hpadr_fifo #(
	parameter int WIDTH = `HPADR_WORD_W,
	parameter int DEPTH = `HPADR_FIFO_DEPTH
)(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	import hpadr_pkg::*;
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("hpadr_fifo: depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (flush_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- design/hpadr_sync.sv
/*
 * Three-stage input synchroniser; a change counts once stages two and
 * three agree.
 * Assumes asynchronous inputs, one clock.
 */
`timescale 1ns/1ns
module hpadr_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	import hpadr_pkg::*;
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	initial
	begin
		if (WIDTH < 1)
			$error("hpadr_sync: width must be at least 1");
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1     <= '0;
			s2     <= '0;
			s3     <= '0;
			sync_o <= '0;
		end
		else
		begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			// per bit: keep old value until two stages agree
			for (int i = 0; i < WIDTH; i++)
				if (s2[i] == s3[i])
					sync_o[i] <= s3[i];
		end
	end
endmodule

//--- tb/hpadr_monitor.sv
/*
 * Port checker for hpadr_top, bound to every instance of it.
 * Assumes a single clk_i domain with rst_i asynchronous, active high.
 */
`timescale 1ns/1ns
module hpadr_monitor (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        hst_stb_i,
	input  wire logic        hst_rnw_i,
	input  wire logic        hst_data_oe_o,
	input  wire logic        cpu_wr_i,
	input  wire logic [1:0]  cpu_addr_i,
	input  wire logic [31:0] cpu_wdata_i,
	input  wire logic        host_to_cpu_irq_o,
	input  wire logic [31:0] dma_wr_addr_o,
	input  wire logic [31:0] dma_wr_data_o,
	input  wire logic        dma_wr_valid_o,
	input  wire logic        dma_wr_ready_i,
	input  wire logic [31:0] dma_rd_addr_o,
	input  wire logic        dma_rd_req_o,
	input  wire logic        dma_rd_ack_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] stb_age;
	// cycles since strobe was high; saturates so long idle spans stay cheap
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			stb_age <= 4'hF;
		else if (hst_stb_i)
			stb_age <= 4'h0;
		else if (stb_age != 4'hF)
			stb_age <= stb_age + 4'h1;
	end
	// ----
	// properties
	// ----
	property p_irq_cause; $rose(host_to_cpu_irq_o) |-> stb_age <= 4'h9; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq flag set without host write");
	property p_irq_hold; host_to_cpu_irq_o && !cpu_wr_i && !$past(cpu_wr_i) |=> host_to_cpu_irq_o; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped without cpu write");
	property p_cpu_clr; cpu_wr_i && cpu_addr_i == 2'h0 && cpu_wdata_i[1] && stb_age == 4'hF |-> ##2 !host_to_cpu_irq_o; endproperty
	a_cpu_clr: assert property (p_cpu_clr) else $error("cpu write of one left irq set");
	property p_oe_rd; $rose(hst_data_oe_o) |-> hst_stb_i && hst_rnw_i; endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("data driven outside a host read");
	property p_oe_drop; !hst_stb_i [*8] |-> !hst_data_oe_o; endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("data still driven after strobe");
	property p_wr_hold; dma_wr_valid_o && !dma_wr_ready_i |=> dma_wr_valid_o && $stable(dma_wr_data_o) && $stable(dma_wr_addr_o); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("dma write changed while stalled");
	property p_rd_hold; dma_rd_req_o && !dma_rd_ack_i |=> dma_rd_req_o && $stable(dma_rd_addr_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("dma read request dropped early");
	property p_wr_cause; $rose(dma_wr_valid_o) |-> stb_age <= 4'hA; endproperty
	a_wr_cause: assert property (p_wr_cause) else $error("dma write without host data");
	property p_rd_cause; $rose(dma_rd_req_o) |-> stb_age == 4'h0 && hst_rnw_i; endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("dma read outside a host read");
endmodule
bind hpadr_top hpadr_monitor i_hpadr_monitor (.clk_i(clk_i), .rst_i(rst_i), .hst_stb_i(hst_stb_i),
	.hst_rnw_i(hst_rnw_i), .hst_data_oe_o(hst_data_oe_o), .cpu_wr_i(cpu_wr_i), .cpu_addr_i(cpu_addr_i),
	.cpu_wdata_i(cpu_wdata_i), .host_to_cpu_irq_o(host_to_cpu_irq_o), .dma_wr_addr_o(dma_wr_addr_o),
	.dma_wr_data_o(dma_wr_data_o), .dma_wr_valid_o(dma_wr_valid_o), .dma_wr_ready_i(dma_wr_ready_i),
	.dma_rd_addr_o(dma_rd_addr_o), .dma_rd_req_o(dma_rd_req_o), .dma_rd_ack_i(dma_rd_ack_i));

//--- tb/hpadr_host_model.sv
/*
 * Host processor model: one strobed transfer per call of xfer.
 * Assumes the port synchronises the strobe on clk_i.
 */
`timescale 1ns/1ns
module hpadr_host_model (
	input  wire logic        clk_i,
	input  wire logic        ready_i,
	input  wire logic        oe_i,
	input  wire logic [31:0] rdata_i,
	output logic             stb_o,
	output logic             rnw_o,
	output logic [1:0]       sel_o,
	output logic [31:0]      data_o
);
	logic to_seen = 1'b0;
	initial
	begin
		stb_o = 1'b0;
		rnw_o = 1'b0;
		sel_o = 2'h0;
		data_o = 32'h0;
	end
	task automatic xfer(input logic rw, input logic [1:0] s, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		int t;
		bit done;
		n = 0;
		t = 0;
		done = 1'b0;
		@(negedge clk_i);
		rnw_o = rw;
		sel_o = s;
		data_o = wd;
		stb_o = 1'b1;
		// writes held a fixed span; a refused read is retried once ready returns
		while (!done && n < 400)
		begin
			@(negedge clk_i);
			n++;
			t++;
			if (t >= 6 && stb_o && (!rw || oe_i))
				done = 1'b1;
			else if (t >= 6 && stb_o && ready_i)
			begin
				stb_o = 1'b0;
				t = 0;
			end
			else if (t >= 6 && !stb_o)
			begin
				stb_o = 1'b1;
				t = 0;
			end
		end
		to_seen = to_seen | !done;
		rd = rdata_i;
		stb_o = 1'b0;
		// released bus shows the inverse, never a stale copy
		data_o = ~wd;
		repeat (6) @(negedge clk_i);
	endtask
endmodule

//--- tb/hpadr_top_tb_top.sv
/*
 * Self-checking bench for hpadr_top: reset values, irq flag, halfword
 * order, address modes, data path, write FIFO fill.
 * Assumes hpadr_host_model on the host pins; DMA memory is modelled here.
 */
`timescale 1ns/1ns
module hpadr_top_tb_top;
	import hpadr_pkg::*;
	localparam int FD = 32;
	logic        clk_i = 1'b0, rst_i = 1'b1, m16 = 1'b0, cwr = 1'b0, crd = 1'b0, stall = 1'b0;
	logic        stb, rnw, oe, rdy, wvld, rreq, irq, wrdy = 1'b1, rack = 1'b0;
	hpadr_sel_t  sel;
	logic [1:0]  cad = 2'h0;
	logic [31:0] cwd = 32'h0, rdat = 32'h0, crdat, hdo, hdi, waddr, wdat, raddr, got, cr;
	logic [31:0] mem [logic [31:0]];
	int          err_total = 0, comparisons = 0, k, n;
	bit          row_cpu [6] = '{0, 0, 0, 1, 1, 0};
	logic [31:0] row_wd [6] = '{32'h0, 32'h2, 32'h1, 32'h0, 32'h2, 32'h0};
	logic [1:0]  row_exp [6] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h1, 2'h0};
	hpadr_top #(.FIFO_DEPTH(FD)) i_hpadr_top (
		.clk_i(clk_i), .rst_i(rst_i), .hst_stb_i(stb), .hst_rnw_i(rnw), .hst_sel_i(sel),
		.hst_mode16_i(m16), .hst_data_i(hdo), .hst_data_o(hdi), .hst_data_oe_o(oe), .hst_ready_o(rdy),
		.cpu_wr_i(cwr), .cpu_rd_i(crd), .cpu_addr_i(cad), .cpu_wdata_i(cwd), .cpu_rdata_o(crdat),
		.host_to_cpu_irq_o(irq), .dma_wr_addr_o(waddr), .dma_wr_data_o(wdat), .dma_wr_valid_o(wvld),
		.dma_wr_ready_i(wrdy), .dma_rd_addr_o(raddr), .dma_rd_req_o(rreq), .dma_rd_ack_i(rack),
		.dma_rd_data_i(rdat));
	hpadr_host_model i_hpadr_host_model (.clk_i(clk_i), .ready_i(rdy), .oe_i(oe), .rdata_i(hdi),
		.stb_o(stb), .rnw_o(rnw), .sel_o(sel), .data_o(hdo));
	initial
		forever #2 clk_i = ~clk_i;
	// ----
	// memory behind DMA; unwritten words read back as the inverted address
	// ----
	always @(posedge clk_i)
		if (wvld && wrdy)
			mem[waddr] = wdat;
	always @(negedge clk_i)
	begin
		wrdy <= !stall;
		rack <= rreq && !rack;
		rdat <= mem.exists(raddr) ? mem[raddr] : ~raddr;
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cpu(input logic w, input logic [1:0] a, input logic [31:0] d);
		@(negedge clk_i);
		cwr = w;
		crd = !w;
		cad = a;
		cwd = d;
		@(negedge clk_i);
		cwr = 1'b0;
		crd = 1'b0;
		cr = crdat;
	endtask
	task automatic hx(input logic rw, input logic [1:0] s, input logic [31:0] wd);
		i_hpadr_host_model.xfer(rw, s, wd, got);
	endtask
	task automatic finish_test();
		if (i_hpadr_host_model.to_seen)
			err_total++;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		for (k = 0; k < 3; k++)
		begin
			cpu(1'b0, k[1:0], 32'h0);
			cmp("reset reg", 32'h0, cr);
		end
		for (k = 0; k < 6; k++)
		begin
			if (row_cpu[k])
				cpu(1'b1, 2'h0, row_wd[k]);
			else
				hx(1'b0, 2'h0, row_wd[k]);
			repeat (20) @(negedge clk_i);
			cpu(1'b0, 2'h0, 32'h0);
			cmp("ctl irq mirror", {30'h0, row_exp[k]}, {30'h0, cr[1], cr[8]});
			cmp("irq line", {31'h0, row_exp[k][1]}, {31'h0, irq});
		end
		hx(1'b0, 2'h1, 32'h0000_1234);
		cpu(1'b1, 2'h1, 32'hFFFF_FFFF);
		for (k = 1; k < 3; k++)
		begin
			cpu(1'b0, k[1:0], 32'h0);
			cmp("single addr", 32'h0000_1234, cr);
		end
		hx(1'b1, 2'h1, 32'h0);
		cmp("single addr read", 32'h0000_1234, got);
		hx(1'b0, 2'h0, 32'h0000_0200);
		hx(1'b0, 2'h1, 32'h0000_00A0);
		hx(1'b0, 2'h2, 32'h0000_00B0);
		for (k = 1; k < 3; k++)
		begin
			cpu(1'b0, k[1:0], 32'h0);
			cmp("dual addr", 32'h0000_0090 + 32'(k) * 32'h10, cr);
		end
		hx(1'b1, 2'h2, 32'h0);
		cmp("dual raddr read", 32'h0000_00B0, got);
		for (k = 0; k < 2; k++)
		begin
			m16 = 1'b0;
			hx(1'b0, 2'h0, 32'h0000_0200 | 32'(k));
			m16 = 1'b1;
			hx(1'b0, 2'h2, 32'h0000_1111);
			cpu(1'b0, 2'h2, 32'h0);
			cmp("half pending", k ? 32'h1111_2222 : 32'h0000_00B0, cr);
			hx(1'b0, 2'h2, 32'h0000_2222);
			cpu(1'b0, 2'h2, 32'h0);
			cmp("half write", k ? 32'h2222_1111 : 32'h1111_2222, cr);
			hx(1'b1, 2'h2, 32'h0);
			cmp("half read 1", 32'h0000_1111, {16'h0, got[15:0]});
			hx(1'b1, 2'h2, 32'h0);
			cmp("half read 2", 32'h0000_2222, {16'h0, got[15:0]});
		end
		m16 = 1'b0;
		hx(1'b1, 2'h2, 32'h0);
		cmp("order ignored", 32'h2222_1111, got);
		hx(1'b0, 2'h1, 32'h0000_0040);
		for (k = 0; k < 3; k++)
			hx(1'b0, 2'h3, 32'hA5A5_0000 + 32'(k));
		repeat (20) @(negedge clk_i);
		hx(1'b0, 2'h2, 32'h0000_0040);
		for (k = 0; k < 3; k++)
		begin
			cmp("dma write", 32'hA5A5_0000 + 32'(k), mem[32'h40 + 32'(k)]);
			hx(1'b1, 2'h3, 32'h0);
			cmp("data read", 32'hA5A5_0000 + 32'(k), got);
		end
		// far side stalls so the write buffer must fill and refuse
		stall = 1'b1;
		hx(1'b0, 2'h1, 32'h0000_0080);
		k = 0;
		while (rdy === 1'b1 && k < 40)
		begin
			hx(1'b0, 2'h3, 32'h0000_0100 + 32'(k));
			k++;
		end
		cmp("fifo depth", 32'h1, {31'h0, k >= FD && k <= FD + 1});
		stall = 1'b0;
		for (n = 0; n < 300 && wvld !== 1'b0; n++)
			@(negedge clk_i);
		repeat (4) @(negedge clk_i);
		cmp("fifo drained", 32'h0, {31'h0, wvld});
		cmp("first word", 32'h0000_0100, mem[32'h80]);
		cmp("last word", 32'h0000_0100 + 32'(k - 1), mem[32'h80 + 32'(k - 1)]);
		cpu(1'b0, 2'h3, 32'h0);
		cmp("cpu data path", 32'h0, cr);
		hx(1'b0, 2'h0, 32'h0000_0002);
		repeat (20) @(negedge clk_i);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		cmp("irq after reset", 32'h0, {31'h0, irq});
		cpu(1'b0, 2'h1, 32'h0);
		cmp("waddr after reset", 32'h0, cr);
		finish_test();
	end
endmodule
